// *** rtl/icm_regs.vh ***
// register map, field positions, codes and timing counts of the i2c master
// assumes a 125 mhz system clock and word-aligned avalon byte addresses
`ifndef ICM_REGS_VH
`define ICM_REGS_VH

// register byte offsets
`define ICM_OFS_PERIOD   5'h00
`define ICM_OFS_CMD      5'h04
`define ICM_OFS_STATE    5'h08
`define ICM_OFS_ADDR     5'h0C
`define ICM_OFS_RXD      5'h10
`define ICM_OFS_TXD      5'h14
`define ICM_OFS_EVT      5'h18
`define ICM_OFS_MASK     5'h1C

// reset values
`define ICM_RST_PERIOD   8'h00
`define ICM_RST_STATE    8'h00
`define ICM_RST_BYTE     8'h00
`define ICM_RST_EVT      2'h0

// command bit positions
`define ICM_CMD_START    5
`define ICM_CMD_STOP     4
`define ICM_CMD_ADDR     3
`define ICM_CMD_SEND     2
`define ICM_CMD_RX_ACK   1
`define ICM_CMD_RX_NACK  0

// address register field
`define ICM_ADDR_RNW     0

// event register fields
`define ICM_EVT_DONE     0
`define ICM_EVT_ERR      1
`define ICM_EVT_BUSY     2

// whole-byte transfer state codes
`define ICM_ST_IDLE      8'h00
`define ICM_ST_START     8'h01
`define ICM_ST_RSTART    8'h02
`define ICM_ST_WA_ACK    8'h34
`define ICM_ST_RA_ACK    8'h2C
`define ICM_ST_WA_NACK   8'h54
`define ICM_ST_RA_NACK   8'h4C
`define ICM_ST_A_ERR     8'hE4
`define ICM_ST_RD_ACK    8'h48
`define ICM_ST_RD_NACK   8'h28
`define ICM_ST_WD_ACK    8'h30
`define ICM_ST_WD_NACK   8'h50
`define ICM_ST_WD_ERR    8'hF0
`define ICM_ST_GEN_ERR   8'hFF

// timing: one microsecond of bit time in system clocks
`define ICM_CLK_MHZ      125
`define ICM_CYC_PER_US   15'd125

`endif

// *** rtl/icm_phase_timer.v ***
// quarter-bit tick generator for the i2c bit engine
// assumes period in microseconds, stalled by hold while scl is stretched
`timescale 1ns/1ns
`include "icm_regs.vh"

module icm_phase_timer #(
  parameter CYC_PER_US = `ICM_CYC_PER_US
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire [7:0] period,
  input  wire       run,
  input  wire       hold,
  output wire       tick
);

  reg  [14:0] count;
  wire [22:0] full;
  wire [14:0] quarter;

  // four phases per bit, remainder of the quarter split is dropped
  assign full    = period * CYC_PER_US;
  assign quarter = full[16:2];
  assign tick    = run && !hold && (count >= quarter - 15'd1);

  always @(posedge clk) begin
    if (!nrst || !run) begin
      count <= 15'h0000;
    end else if (!hold) begin
      if (tick) begin
        count <= 15'h0000;
      end else begin
        count <= count + 15'd1;
      end
    end
  end

endmodule

// *** rtl/icm_master.v ***
// command driven i2c master with avalon-mm register slave
// assumes open-drain scl/sda resolved outside; pins arrive asynchronous
//
// What this block does
// [RULE1] bit time is period setting microseconds, zero stops
// [RULE2] six one-hot commands, start and stop bits
// [RULE3] address command sends address with direction bit
// [RULE4] send command transmits the transmit byte
// [RULE5] receive with ack, or receive with nack
// [RULE6] status byte bits error, nack, ack, modes, starts
// [RULE7] start command completion sets start status
// [RULE8] address or data completion shown in bits 2-6
// [RULE9] software sends stop after an error
// [RULE10] start and address phase status codes
// [RULE11] data phase status codes
// [RULE12] address register: address high, direction bit 0
// [RULE13] received byte holds last read byte
// [RULE14] transmit byte feeds the next send command
// [RULE15] software orders period, start, address, data, stop
// [RULE16] start mid-transfer gives repeated start
// [RULE17] error held until stop, stop returns idle
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`include "icm_regs.vh"

module icm_master (
  input  wire        clk,
  input  wire        nrst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         irq,
  input  wire        scl_i,
  output reg         scl_o,
  output reg         scl_oe,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe
);

  localparam M_IDLE  = 2'd0;
  localparam M_START = 2'd1;
  localparam M_STOP  = 2'd2;
  localparam M_BYTE  = 2'd3;

  localparam K_ADDR  = 2'd0;
  localparam K_TX    = 2'd1;
  localparam K_RX    = 2'd2;

  // registers
  reg  [7:0] bit_period_setting;
  reg  [7:0] transfer_state;
  reg  [7:0] target_address_byte;
  reg  [7:0] received_byte;
  reg  [7:0] transmit_byte;
  reg  [1:0] evt;
  reg  [1:0] evt_mask;

  // engine
  reg  [1:0] mode;
  reg  [1:0] kind;
  reg  [1:0] ph;
  reg  [3:0] bitn;
  reg  [7:0] shreg;
  reg        send_ack;
  reg        lost;
  reg        nack_seen;
  reg        started;
  reg        err_hold;
  reg        done_pulse;
  reg        err_pulse;

  // pin synchronisers
  reg  [1:0] scl_sync;
  reg  [1:0] sda_sync;
  wire       scl_s = scl_sync[1];
  wire       sda_s = sda_sync[1];

  wire       acc     = (avs_read || avs_write) && !avs_waitrequest;
  wire       wr_acc  = acc && avs_write;
  wire       busy    = (mode != M_IDLE);
  wire       read_not_write_flag = target_address_byte[`ICM_ADDR_RNW];
  wire [7:0] cmd     = avs_writedata[7:0];
  wire       cmd_wr  = wr_acc && (avs_address == `ICM_OFS_CMD);
  // commands are dropped while a phase runs or the bus is disabled
  wire       cmd_ok  = cmd_wr && !busy &&
                       (bit_period_setting != 8'h00);  // [RULE1]
  wire       tick;
  // scl released by us but still low: slave is stretching
  wire       hold    = busy && !scl_oe && !scl_s;

  function onehot6;
    input [5:0] v;
    begin
      onehot6 = (v != 6'h00) && ((v & (v - 6'h01)) == 6'h00);
    end
  endfunction

  function [31:0] rd_mux;
    input [4:0] a;
    begin
      case (a)
        `ICM_OFS_PERIOD: rd_mux = {24'h00_0000, bit_period_setting};
        `ICM_OFS_STATE:  rd_mux = {24'h00_0000, transfer_state};
        `ICM_OFS_ADDR:   rd_mux = {24'h00_0000, target_address_byte};
        `ICM_OFS_RXD:    rd_mux = {24'h00_0000, received_byte};
        `ICM_OFS_TXD:    rd_mux = {24'h00_0000, transmit_byte};
        `ICM_OFS_EVT:    rd_mux = {29'h0000_0000, busy, evt};
        `ICM_OFS_MASK:   rd_mux = {30'h0000_0000, evt_mask};
        default:         rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  icm_phase_timer #(
    .CYC_PER_US (`ICM_CYC_PER_US)
  ) u_timer (
    .clk    (clk),
    .nrst   (nrst),
    .period (bit_period_setting),
    .run    (busy),
    .hold   (hold),
    .tick   (tick)
  );

  always @(posedge clk) begin
    if (!nrst) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
    end
  end

  // avalon slave: waitrequest drops one cycle after the request
  always @(posedge clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rd_mux(avs_address);
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // software-owned registers
  always @(posedge clk) begin
    if (!nrst) begin
      bit_period_setting  <= `ICM_RST_PERIOD;
      target_address_byte <= `ICM_RST_BYTE;
      transmit_byte       <= `ICM_RST_BYTE;
      evt_mask            <= `ICM_RST_EVT;
    end else if (wr_acc) begin
      case (avs_address)
        `ICM_OFS_PERIOD: bit_period_setting  <= cmd;  // [RULE1]
        `ICM_OFS_ADDR:   target_address_byte <= cmd;  // [RULE12]
        `ICM_OFS_TXD:    transmit_byte       <= cmd;  // [RULE14]
        `ICM_OFS_MASK:   evt_mask            <= avs_writedata[1:0];
        default:         evt_mask            <= evt_mask;
      endcase
    end
  end

  // sticky events, a new event beats a same-cycle clear
  always @(posedge clk) begin
    if (!nrst) begin
      evt <= `ICM_RST_EVT;
      irq <= 1'b0;
    end else begin
      if (wr_acc && avs_address == `ICM_OFS_EVT) begin
        evt <= (evt & ~avs_writedata[1:0]) | {err_pulse, done_pulse};
      end else begin
        evt <= evt | {err_pulse, done_pulse};
      end
      irq <= |(evt & evt_mask);
    end
  end

  // command decode and bit engine
  always @(posedge clk) begin
    if (!nrst) begin
      mode           <= M_IDLE;
      kind           <= K_ADDR;
      ph             <= 2'd0;
      bitn           <= 4'd0;
      shreg          <= 8'h00;
      send_ack       <= 1'b0;
      lost           <= 1'b0;
      nack_seen      <= 1'b0;
      started        <= 1'b0;
      err_hold       <= 1'b0;
      done_pulse     <= 1'b0;
      err_pulse      <= 1'b0;
      transfer_state <= `ICM_ST_IDLE;
      received_byte  <= `ICM_RST_BYTE;
      scl_o          <= 1'b0;
      sda_o          <= 1'b0;
      scl_oe         <= 1'b0;
      sda_oe         <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      err_pulse  <= 1'b0;
      if (cmd_ok && cmd[7:6] == 2'b00 && cmd[5:0] != 6'h00) begin
        ph   <= 2'd0;
        bitn <= 4'd0;
        lost <= 1'b0;
        if (!onehot6(cmd[5:0])) begin
          // more than one command bit at once
          transfer_state <= `ICM_ST_GEN_ERR;  // [RULE11]
          err_hold       <= 1'b1;
          err_pulse      <= 1'b1;
        end else if (cmd[`ICM_CMD_STOP]) begin
          mode <= M_STOP;  // [RULE2]
        end else if (err_hold) begin
          // only a stop leaves the error state
          transfer_state <= transfer_state;  // [RULE17]
        end else if (cmd[`ICM_CMD_START]) begin
          mode <= M_START;  // [RULE2] [RULE16]
        end else if (!started) begin
          // byte commands need a start condition first
          transfer_state <= `ICM_ST_GEN_ERR;
          err_hold       <= 1'b1;
          err_pulse      <= 1'b1;
        end else if (cmd[`ICM_CMD_ADDR]) begin
          mode  <= M_BYTE;
          kind  <= K_ADDR;
          shreg <= target_address_byte;  // [RULE3]
        end else if (cmd[`ICM_CMD_SEND]) begin
          mode  <= M_BYTE;
          kind  <= K_TX;
          shreg <= transmit_byte;  // [RULE4]
        end else begin
          mode     <= M_BYTE;
          kind     <= K_RX;
          send_ack <= cmd[`ICM_CMD_RX_ACK];  // [RULE5]
        end
      end else if (tick) begin
        ph <= ph + 2'd1;
        case (mode)
          M_START: begin
            case (ph)
              2'd0: sda_oe <= 1'b0;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= 1'b1;
              default: begin
                scl_oe     <= 1'b1;
                mode       <= M_IDLE;
                started    <= 1'b1;
                done_pulse <= 1'b1;
                transfer_state <= started ? `ICM_ST_RSTART
                                          : `ICM_ST_START;  // [RULE7]
              end
            endcase
          end
          M_STOP: begin
            case (ph)
              2'd0: sda_oe <= 1'b1;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= 1'b0;
              default: begin
                mode           <= M_IDLE;
                started        <= 1'b0;
                err_hold       <= 1'b0;  // [RULE17]
                done_pulse     <= 1'b1;
                transfer_state <= `ICM_ST_IDLE;  // [RULE10]
              end
            endcase
          end
          M_BYTE: begin
            case (ph)
              2'd0: begin
                if (bitn == 4'd8) begin
                  sda_oe <= (kind == K_RX) && send_ack;  // [RULE5]
                end else begin
                  sda_oe <= (kind != K_RX) && !shreg[7];
                end
              end
              2'd1: scl_oe <= 1'b0;
              2'd2: begin
                if (bitn == 4'd8) begin
                  nack_seen <= sda_s;
                end else if (kind == K_RX) begin
                  shreg <= {shreg[6:0], sda_s};
                end else if (shreg[7] && !sda_s) begin
                  // released a one but the line stayed low
                  lost <= 1'b1;
                end
              end
              default: begin
                scl_oe <= 1'b1;
                if (bitn != 4'd8) begin
                  bitn <= bitn + 4'd1;
                  if (kind != K_RX) begin
                    shreg <= {shreg[6:0], 1'b0};
                  end
                end else begin
                  // sda kept: releasing it as scl falls breaks data hold
                  mode       <= M_IDLE;
                  done_pulse <= 1'b1;
                  err_pulse  <= lost;
                  err_hold   <= lost;
                end
              end
            endcase
          end
          default: ph <= 2'd0;
        endcase
      end else if (mode == M_IDLE && done_pulse && kind == K_RX &&
                   transfer_state != `ICM_ST_IDLE && bitn == 4'd8) begin
        bitn <= 4'd0;
      end
      // completion codes once a byte phase has ended
      if (tick && mode == M_BYTE && ph == 2'd3 && bitn == 4'd8) begin
        case (kind)
          K_ADDR: begin
            if (lost) begin
              transfer_state <= `ICM_ST_A_ERR;  // [RULE10]
            end else if (nack_seen) begin
              transfer_state <= read_not_write_flag ? `ICM_ST_RA_NACK
                                                    : `ICM_ST_WA_NACK;
            end else begin
              transfer_state <= read_not_write_flag ? `ICM_ST_RA_ACK
                                                    : `ICM_ST_WA_ACK;
            end  // [RULE8]
          end
          K_TX: begin
            if (lost) begin
              transfer_state <= `ICM_ST_WD_ERR;  // [RULE11]
            end else if (nack_seen) begin
              transfer_state <= `ICM_ST_WD_NACK;
            end else begin
              transfer_state <= `ICM_ST_WD_ACK;  // [RULE8]
            end
          end
          default: begin
            received_byte  <= shreg;  // [RULE13]
            transfer_state <= send_ack ? `ICM_ST_RD_ACK
                                       : `ICM_ST_RD_NACK;  // [RULE11]
          end
        endcase
      end
    end
  end

  // status bit meaning is carried by the codes above  [RULE6]

endmodule

// *** bench/icm_master_asserts.sv ***
// assertions on the i2c master register bus and scl timing
// assumes open-drain wires resolved by the bench; bound to icm_master
`timescale 1ns/1ns
`include "icm_regs.vh"

module icm_master_asserts (
  input wire        clk,
  input wire        nrst,
  input wire [4:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        irq,
  input wire        scl_i,
  input wire        scl_o,
  input wire        scl_oe,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe
);
  reg  [7:0]  per;
  reg         per_seen;
  reg         oe_prev;
  reg  [15:0] oe_cnt;
  wire        ack = !avs_waitrequest;
  wire        req = avs_read | avs_write;
  wire        rok = avs_read & ack;

  // shadow period; run length of scl_oe, saturating
  always @(posedge clk) begin
    if (!nrst) begin
      per <= `ICM_RST_PERIOD;
      per_seen <= 1'b0;
      oe_prev <= 1'b0;
      oe_cnt <= 16'h0000;
    end else begin
      if (avs_write && ack && avs_address == `ICM_OFS_PERIOD) begin
        per <= avs_writedata[7:0];
        per_seen <= per_seen | (|avs_writedata[7:0]);
      end
      oe_prev <= scl_oe;
      if (scl_oe != oe_prev)
        oe_cnt <= 16'h0000;
      else if (oe_cnt != 16'hFFFF)
        oe_cnt <= oe_cnt + 16'h0001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_ANSWER: assert property (req && avs_waitrequest |=> ack)
    else $error("request not answered next cycle");
  AST_WAIT_ONE: assert property (ack |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_CMD_READ_ZERO: assert property (
    rok && avs_address == `ICM_OFS_CMD |-> avs_readdata == 32'h0000_0000)
    else $error("command register not write only");
  AST_STATE_CODE: assert property (
    rok && avs_address == `ICM_OFS_STATE |-> avs_readdata[7:0] inside
    {8'h00, 8'h01, 8'h02, 8'h34, 8'h2C, 8'h54, 8'h4C, 8'hE4, 8'h48,
     8'h28, 8'h30, 8'h50, 8'hF0, 8'hFF})
    else $error("status byte not a listed code");
  AST_OFF_UNTIL_PERIOD: assert property (
    !per_seen |-> !scl_oe && !sda_oe)
    else $error("bus driven with period zero");
  // stretching only lengthens, so only the lower bound is safe
  AST_SCL_HIGH_TIME: assert property (
    per == 8'h01 && $rose(scl_oe) |-> oe_cnt >= 16'h0037)
    else $error("scl released for under two quarters");
  AST_SCL_LOW_TIME: assert property (
    per == 8'h01 && $fell(scl_oe) |-> oe_cnt >= 16'h0037)
    else $error("scl pulled for under two quarters");
  AST_STRETCH_HOLD: assert property (
    !scl_oe && !scl_i |=> !scl_oe)
    else $error("scl pulled while slave stretches");

  COV_STRETCH: cover property (!scl_oe && !scl_i);
  COV_ERR: cover property (rok && avs_readdata[7:0] == 8'hF0);
  COV_IRQ: cover property ($fell(irq));
endmodule

bind icm_master icm_master_asserts u_icm_master_asserts (
  .clk(clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe));

// *** bench/icm_slave_model.sv ***
// behavioural i2c slave: one address, counting read data, fault knobs
// assumes pull-up wires resolved by the bench from all pull-downs
`timescale 1ns/1ns

module icm_slave_model #(
  parameter [6:0] DEV_ADDR = 7'h50
) (
  input  wire       scl,
  input  wire       sda,
  input  wire       refuse,
  input  wire       stretch,
  input  wire       jam,
  output wire       scl_low,
  output wire       sda_low,
  output reg  [7:0] got
);
  reg [7:0] sh = 8'h00;
  reg [7:0] rdat = 8'hA5;
  reg       act = 1'b0, first = 1'b0, rd = 1'b0, mine = 1'b0;
  reg       mack = 1'b0, drv = 1'b0, hold = 1'b0;
  integer   n = 0;

  // jam stands for a stuck device fighting the master
  assign sda_low = drv | jam;
  assign scl_low = hold;
  initial got = 8'h00;

  always @(negedge sda) if (scl) begin
    act = 1'b1;
    first = 1'b1;
    rd = 1'b0;
    drv = 1'b0;
    n = -1;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    drv = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (n < 8)
      sh = {sh[6:0], sda};
    else
      mack = !sda;
  end
  // slow answer: longer than two quarters at period 1
  always @(negedge scl) if (stretch) begin
    hold = 1'b1;
    #600 hold = 1'b0;
  end
  always @(negedge scl) if (act) begin
    n = n + 1;
    if (n == 9) begin
      n = 0;
      drv = rd && (first || mack) && !rdat[7];
      first = 1'b0;
    end else if (n == 8) begin
      if (first) begin
        mine = sh[7:1] == DEV_ADDR;
        rd = mine & sh[0];
      end
      if (rd && !first)
        rdat = rdat + 8'h01;
      else
        got = sh;
      drv = mine && (first || !(rd || refuse));
    end else if (rd && n > 0)
      drv = !rdat[7 - n];
  end
endmodule

// *** bench/icm_master_bench.sv ***
// self-checking bench: registers, i2c phases, faults, interrupt
// assumes the slave model on pull-up wires and period 1
`timescale 1ns/1ns
`include "icm_regs.vh"

module icm_master_bench;
  reg         clk, nrst, avs_read, avs_write, refuse, stretch, jam;
  reg  [4:0]  avs_address;
  reg  [31:0] avs_writedata, q;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, irq, scl_o, scl_oe, sda_o, sda_oe;
  wire        scl_low, sda_low;
  wire [7:0]  got;
  wire        scl_w = !(scl_oe | scl_low);
  wire        sda_w = !(sda_oe | sda_low);
  integer     errors, n_compared, cyc, i;

  icm_master u_icm_master (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
  icm_slave_model u_icm_slave_model (.scl(scl_w), .sda(sda_w),
    .refuse(refuse), .stretch(stretch), .jam(jam),
    .scl_low(scl_low), .sda_low(sda_low), .got(got));

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask

  // one avalon access; read data kept in q; a hang ends by the timeout
  task bus(input rw, input [4:0] a, input [7:0] d);
    begin
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_read <= rw;
      avs_write <= !rw;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask

  // command, wait for done or error when w, then state compare
  task ph(input [7:0] c, input [7:0] st, input w);
    begin
      bus(0, `ICM_OFS_EVT, 8'h03);
      bus(0, `ICM_OFS_CMD, c);
      q = 32'h0000_0000;
      while (w && q[1:0] == 2'b00)
        bus(1, `ICM_OFS_EVT, 8'h00);
      bus(1, `ICM_OFS_STATE, 8'h00);
      chk(q, {24'h00_0000, st});
    end
  endtask

  task summarize;
    begin
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      errors = errors + 1;
      summarize;
    end
  end

  initial begin
    errors = 0;
    n_compared = 0;
    cyc = 0;
    {nrst, avs_read, avs_write, refuse, stretch, jam} = 6'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 8; i = i + 1) begin
      bus(1, {i[2:0], 2'b00}, 8'h00);
      chk(q, 32'h0000_0000);
    end
    ph(8'h20, 8'h00, 0);
    chk({scl_oe, sda_oe, scl_o, sda_o}, 4'h0);
    bus(0, `ICM_OFS_PERIOD, 8'h01);
    bus(1, `ICM_OFS_PERIOD, 8'h00);
    chk(q, 32'h0000_0001);
    ph(8'h03, 8'hFF, 1);
    ph(8'h20, 8'hFF, 0);
    ph(8'h10, 8'h00, 1);
    bus(0, `ICM_OFS_MASK, 8'h01);
    stretch <= 1'b1;
    ph(8'h20, 8'h01, 1);
    chk(irq, 1'b1);
    bus(0, `ICM_OFS_ADDR, 8'hA0);
    bus(1, `ICM_OFS_ADDR, 8'h00);
    chk(q, 32'h0000_00A0);
    ph(8'h08, 8'h34, 1);
    chk(got, 8'hA0);
    bus(0, `ICM_OFS_TXD, 8'h12);
    ph(8'h04, 8'h30, 1);
    chk(got, 8'h12);
    stretch <= 1'b0;
    ph(8'h20, 8'h02, 1);
    bus(0, `ICM_OFS_ADDR, 8'hA1);
    ph(8'h08, 8'h2C, 1);
    ph(8'h02, 8'h48, 1);
    bus(1, `ICM_OFS_RXD, 8'h00);
    chk(q, 32'h0000_00A5);
    ph(8'h01, 8'h28, 1);
    bus(1, `ICM_OFS_RXD, 8'h00);
    chk(q, 32'h0000_00A6);
    ph(8'h20, 8'h02, 1);
    bus(0, `ICM_OFS_ADDR, 8'hA2);
    ph(8'h08, 8'h54, 1);
    ph(8'h20, 8'h02, 1);
    bus(0, `ICM_OFS_ADDR, 8'hA3);
    ph(8'h08, 8'h4C, 1);
    ph(8'h20, 8'h02, 1);
    bus(0, `ICM_OFS_ADDR, 8'hA0);
    ph(8'h08, 8'h34, 1);
    refuse <= 1'b1;
    ph(8'h04, 8'h50, 1);
    refuse <= 1'b0;
    jam <= 1'b1;
    ph(8'h04, 8'hF0, 1);
    ph(8'h02, 8'hF0, 0);
    jam <= 1'b0;
    ph(8'h10, 8'h00, 1);
    ph(8'h04, 8'hFF, 1);
    ph(8'h10, 8'h00, 1);
    ph(8'h20, 8'h01, 1);
    jam <= 1'b1;
    ph(8'h08, 8'hE4, 1);
    jam <= 1'b0;
    ph(8'h10, 8'h00, 1);
    chk(irq, 1'b1);
    bus(0, `ICM_OFS_MASK, 8'h00);
    @(posedge clk);
    chk(irq, 1'b0);
    summarize;
  end
endmodule
